/* File: design/nv_resistor_defs.svh */
// Contract
// - Three setting registers sit at F8h, F9h and FAh for resistors 0, 1, 2.
// - Every setting comes up at 7Fh, the maximum position.
// - A setting above 7Fh sets its top bit, putting that resistor in high impedance.
// - The low seven bits pick one of 128 positions, 0 minimum, 7Fh maximum.
// - Nonvolatile programming starts only after the stop that ends the write.
// - Received address bits are compared with the wired address-select pins.
// - Data line is only pulled low or released; clock is input only.
// - Address byte is 1010 plus three pins plus direction; one-pin variant 101000.
// - No acknowledge while the nonvolatile write runs; master polls or waits.
`ifndef NV_RESISTOR_DEFS_SVH
`define NV_RESISTOR_DEFS_SVH
`define SETTING0_OFFSET   8'hf8
`define SETTING1_OFFSET   8'hf9
`define SETTING2_OFFSET   8'hfa
`define SETTING_RESET     8'h7f
`define HIZ_BIT           7
`define ADDR_PREFIX_3PIN  4'ha
`define ADDR_PREFIX_1PIN  6'h28
`define MCLK_HZ           10000000
`define NV_WRITE_TIME_MS  20
`define WRITE_TIMER_W     18
`endif

/* File: design/nv_resistor_pkg.sv */
package nv_resistor_pkg;
  `include "nv_resistor_defs.svh"

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_DEV   = 6'b00_0010,
    ST_REGA  = 6'b00_0100,
    ST_WDATA = 6'b00_1000,
    ST_RDATA = 6'b01_0000,
    ST_BUSY  = 6'b10_0000
  } engine_state_e;

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_last;
    logic sda_meta;
    logic sda_sync;
    logic sda_last;
  } sampler_state_s;

  typedef struct packed {
    engine_state_e               state;
    logic [7:0]                  shift;
    logic [3:0]                  count;
    logic                        ack_drive;
    logic [7:0]                  reg_ptr;
    logic [7:0]                  tx_byte;
    logic [7:0]                  pend_data;
    logic [1:0]                  pend_index;
    logic                        pend_valid;
    logic [`WRITE_TIMER_W-1:0]   timer;
    logic                        sda_oe;
    logic [2:0]                  pin_meta;
    logic [2:0]                  pin_sync;
    logic [2:0][7:0]             setting;
  } engine_state_s;
endpackage

/* File: design/bit_link_if.sv */
`timescale 1ns/1ps
interface bit_link_if;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic start;
  logic stop;
  modport sampler (output scl_rise, output scl_fall, output sda, output start, output stop);
  modport engine  (input scl_rise, input scl_fall, input sda, input start, input stop);
endinterface

/* File: design/line_sampler.sv */
`timescale 1ns/1ps
module line_sampler
  import nv_resistor_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   srst,
  input  wire logic   scl,
  input  wire logic   sda_in,
  bit_link_if.sampler link
);
  sampler_state_s st_reg;
  sampler_state_s st_next;

  always_comb begin
    st_next          = st_reg;
    st_next.scl_meta = scl;
    st_next.scl_sync = st_reg.scl_meta;
    st_next.scl_last = st_reg.scl_sync;
    st_next.sda_meta = sda_in;
    st_next.sda_sync = st_reg.sda_meta;
    st_next.sda_last = st_reg.sda_sync;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '{default: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.scl_rise = st_reg.scl_sync & ~st_reg.scl_last;
  assign link.scl_fall = ~st_reg.scl_sync & st_reg.scl_last;
  assign link.sda      = st_reg.sda_sync;
  assign link.start    = st_reg.scl_sync & st_reg.scl_last & st_reg.sda_last & ~st_reg.sda_sync;
  assign link.stop     = st_reg.scl_sync & st_reg.scl_last & ~st_reg.sda_last & st_reg.sda_sync;
endmodule

/* File: design/nv_resistor_setting_bank.sv */
`timescale 1ns/1ps
`include "nv_resistor_defs.svh"
module nv_resistor_setting_bank
  import nv_resistor_pkg::*;
#(
  parameter logic                      ONE_PIN_VARIANT   = 1'b0,
  parameter logic [`WRITE_TIMER_W-1:0] WRITE_TIME_CYCLES =
    `WRITE_TIMER_W'((`NV_WRITE_TIME_MS * (`MCLK_HZ / 1000)))
)
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       address_select_pin_0,
  input  wire logic       address_select_pin_1,
  input  wire logic       address_select_pin_2,
  output logic [7:0]      resistor0_position,
  output logic [7:0]      resistor1_position,
  output logic [7:0]      resistor2_position,
  output logic            nv_busy
);
  bit_link_if link ();

  line_sampler u_sampler (
    .mclk   (mclk),
    .srst   (srst),
    .scl    (scl),
    .sda_in (sda_in),
    .link   (link)
  );

  engine_state_s         st_reg;
  engine_state_s         st_next;
  logic                  addr_match;
  logic [6:0]            own_addr;
  logic                  ptr_mapped;
  logic [1:0]            ptr_index;
  logic [2:0]            addr_hit;
  logic                  byte_done;
  logic                  ack_done;
  logic                  read_dir;
  logic                  bus_live;
  logic                  commit;
  logic [7:0]            read_byte;
  wire logic [2:0]       commit_sel;
  wire logic [2:0][7:0]  setting_upd;
  wire logic [2:0][7:0]  position_out;

  always_comb begin
    if (ONE_PIN_VARIANT) begin
      own_addr = {`ADDR_PREFIX_1PIN, st_reg.pin_sync[0]};
    end else begin
      own_addr = {`ADDR_PREFIX_3PIN, st_reg.pin_sync[2:0]};
    end
    addr_match  = (st_reg.shift[7:1] == own_addr);
    read_dir    = st_reg.shift[0];
    addr_hit[0] = (st_reg.reg_ptr == `SETTING0_OFFSET);
    addr_hit[1] = (st_reg.reg_ptr == `SETTING1_OFFSET);
    addr_hit[2] = (st_reg.reg_ptr == `SETTING2_OFFSET);
    ptr_mapped  = |addr_hit;
    case (addr_hit)
      3'b010: begin
        ptr_index = 2'h1;
      end
      3'b100: begin
        ptr_index = 2'h2;
      end
      default: begin
        ptr_index = 2'h0;
      end
    endcase
    read_byte = 8'h00;
    if (ptr_mapped) begin
      read_byte = st_reg.setting[ptr_index];
    end
    byte_done = link.scl_fall && (st_reg.count == 4'h8) && !st_reg.ack_drive;
    ack_done  = link.scl_fall && st_reg.ack_drive;
    bus_live  = (st_reg.state != ST_BUSY);
    // timed write ends on the last count.
    commit    = (st_reg.state == ST_BUSY) && (st_reg.timer <= `WRITE_TIMER_W'(1));
  end

  // whole byte stored with control bit.
  for (genvar gi = 0; gi < 3; gi++) begin : g_setting
    assign commit_sel[gi]   = commit && (st_reg.pend_index == 2'(gi));
    assign setting_upd[gi]  = commit_sel[gi] ? st_reg.pend_data : st_reg.setting[gi];
    assign position_out[gi] = st_reg.setting[gi];
  end

  always_comb begin
    st_next          = st_reg;
    st_next.pin_meta = {address_select_pin_2, address_select_pin_1, address_select_pin_0};
    st_next.pin_sync = st_reg.pin_meta;
    case (st_reg.state)
      ST_BUSY: begin
        st_next.sda_oe    = 1'b0;
        st_next.ack_drive = 1'b0;
        if (commit) begin
          // top bit kept as high-impedance control.
          st_next.setting                    = setting_upd;
          st_next.pend_valid                 = 1'b0;
          st_next.timer                      = '0;
          st_next.state                      = ST_IDLE;
        end else begin
          st_next.timer = st_reg.timer - `WRITE_TIMER_W'(1);
        end
      end
      ST_IDLE: begin
        st_next.sda_oe    = 1'b0;
        st_next.ack_drive = 1'b0;
      end
      ST_DEV, ST_REGA, ST_WDATA: begin
        if (link.scl_rise && st_reg.count < 4'h8) begin
          st_next.shift = {st_reg.shift[6:0], link.sda};
          st_next.count = st_reg.count + 4'h1;
        end else if (byte_done) begin
          st_next.ack_drive = 1'b1;
          if (st_reg.state == ST_DEV && !addr_match) begin
            st_next.ack_drive = 1'b0;
            st_next.state     = ST_IDLE;
          end else begin
            st_next.sda_oe = 1'b1;
            if (st_reg.state == ST_REGA) begin
              st_next.reg_ptr = st_reg.shift;
            end
            if (st_reg.state == ST_WDATA) begin
              st_next.pend_data  = st_reg.shift;
              st_next.pend_index = ptr_index;
              st_next.pend_valid = ptr_mapped;
            end
          end
        end else if (ack_done) begin
          st_next.ack_drive = 1'b0;
          st_next.sda_oe    = 1'b0;
          st_next.count     = 4'h0;
          case (st_reg.state)
            ST_DEV: begin
              if (read_dir) begin
                st_next.tx_byte = read_byte;
                st_next.sda_oe  = ~read_byte[7];
                st_next.state   = ST_RDATA;
              end else begin
                st_next.state = ST_REGA;
              end
            end
            ST_REGA: begin
              st_next.state = ST_WDATA;
            end
            default: begin
              st_next.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_RDATA: begin
        if (link.scl_rise) begin
          st_next.count = st_reg.count + 4'h1;
        end else if (link.scl_fall && st_reg.count != 4'h0) begin
          if (st_reg.count < 4'h8) begin
            st_next.tx_byte = {st_reg.tx_byte[6:0], 1'b0};
            st_next.sda_oe  = ~st_reg.tx_byte[6];
          end else begin
            st_next.sda_oe = 1'b0;
            st_next.state  = ST_IDLE;
          end
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
    if (bus_live) begin
      if (link.start) begin
        st_next.state      = ST_DEV;
        st_next.count      = 4'h0;
        st_next.ack_drive  = 1'b0;
        st_next.sda_oe     = 1'b0;
        st_next.pend_valid = 1'b0;
      end else if (link.stop) begin
        st_next.ack_drive = 1'b0;
        st_next.sda_oe    = 1'b0;
        if (st_reg.pend_valid) begin
          st_next.state = ST_BUSY;
          st_next.timer = WRITE_TIME_CYCLES;
        end else begin
          st_next.state = ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg            <= '0;
      st_reg.state      <= ST_IDLE;
      st_reg.setting[0] <= `SETTING_RESET;
      st_reg.setting[1] <= `SETTING_RESET;
      st_reg.setting[2] <= `SETTING_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // low seven bits give the position.
  assign resistor0_position = position_out[0];
  assign resistor1_position = position_out[1];
  assign resistor2_position = position_out[2];
  assign sda_oe             = st_reg.sda_oe;
  assign sda_out            = st_reg.pend_valid & 1'b0;
  assign nv_busy            = st_reg.state[5];
endmodule

/* File: test/nv_resistor_checker.sv */
`timescale 1ns/1ps
`include "nv_resistor_defs.svh"
module nv_resistor_checker
  import nv_resistor_pkg::*;
#(
  parameter logic [`WRITE_TIMER_W-1:0] WRITE_TIME_CYCLES = `WRITE_TIMER_W'(1)
)
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       scl,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] resistor0_position,
  input wire logic [7:0] resistor1_position,
  input wire logic [7:0] resistor2_position,
  input wire logic       nv_busy
);
  logic [`WRITE_TIMER_W:0] busy_cnt;
  logic [3:0]              stop_age;
  wire  [23:0]             pos = {resistor2_position, resistor1_position, resistor0_position};
  always_ff @(posedge mclk) begin
    busy_cnt <= (nv_busy && !srst) ? busy_cnt + 1'b1 : '0;
    if (srst) stop_age <= 4'hf;
    else if (scl && $past(scl) && $rose(sda_in)) stop_age <= 4'h0;
    else if (stop_age != 4'hf) stop_age <= stop_age + 4'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  drive_low_a: assert property (sda_out == 1'b0) else $error("sda_out driven high");
  oe_steady_a: assert property (scl && $past(scl) |-> $stable(sda_oe)) else $error("sda moved in scl high");
  busy_quiet_a: assert property (nv_busy |-> !sda_oe) else $error("ack while busy");
  busy_after_stop_a: assert property ($rose(nv_busy) |-> stop_age <= 4'h8) else $error("busy without stop");
  busy_length_a: assert property ($fell(nv_busy) |->
    busy_cnt >= WRITE_TIME_CYCLES - 1 && busy_cnt <= WRITE_TIME_CYCLES + 1) else $error("busy length wrong");
  update_at_end_a: assert property ($changed(pos) |-> $fell(nv_busy)) else $error("setting changed early");
  one_setting_a: assert property ($countones({$changed(resistor0_position), $changed(resistor1_position),
    $changed(resistor2_position)}) <= 1) else $error("two settings changed");
  reset_values_a: assert property ($fell(srst) |-> pos == 24'h7f_7f7f && !nv_busy && !sda_oe)
    else $error("bad reset values");
  cover property ($fell(nv_busy));
  cover property ($rose(sda_oe));
  cover property ($rose(resistor1_position[7]));
endmodule
bind nv_resistor_setting_bank nv_resistor_checker #(.WRITE_TIME_CYCLES(WRITE_TIME_CYCLES)) checker_i (
  .mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .resistor0_position(resistor0_position), .resistor1_position(resistor1_position),
  .resistor2_position(resistor2_position), .nv_busy(nv_busy));

/* File: test/bus_master_model.sv */
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  task automatic step(input logic c, input logic d, input int n);
    scl <= c;
    sda_low <= d;
    repeat (n) @(posedge mclk);
  endtask
  task automatic start();
    step(1'b0, 1'b0, 3);
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 4);
    step(1'b0, 1'b1, 1);
  endtask
  task automatic stop();
    step(1'b0, 1'b1, 3);
    step(1'b1, 1'b1, 4);
    step(1'b1, 1'b0, 4);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, (i > 0) && !tx[(i + 7) % 8], 3);
      step(1'b1, (i > 0) && !tx[(i + 7) % 8], 4);
      if (i > 0) rx[i - 1] = sda;
      else ack = !sda;
      step(1'b0, (i > 0) && !tx[(i + 7) % 8], 1);
    end
  endtask
  task automatic write_reg(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic [2:0] ak);
    logic [7:0] rx;
    start();
    xfer(dev, rx, ak[2]);
    xfer(ra, rx, ak[1]);
    xfer(d, rx, ak[0]);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] dev, input logic [7:0] ra, output logic [7:0] d, output logic [2:0] ak);
    logic [7:0] rx;
    start();
    xfer(dev, rx, ak[2]);
    xfer(ra, rx, ak[1]);
    start();
    xfer(dev | 8'h01, rx, ak[0]);
    xfer(8'hff, d, rx[0]);
    stop();
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "nv_resistor_defs.svh"
module tb_top;
  import nv_resistor_pkg::*;
  logic            mclk, srst, scl, sda_low, sda_oe, sda_out, nv_busy;
  logic [2:0]      pins, ak;
  logic [2:0][7:0] pos, exp_pos;
  logic [7:0]      v, rd;
  logic [31:0]     seed;
  int              bad_count, num_checks, cycles, k;
  wire             sda = !(sda_low || (sda_oe && !sda_out));
  nv_resistor_setting_bank #(.WRITE_TIME_CYCLES(`WRITE_TIMER_W'(400))) nv_resistor_setting_bank_i (
    .mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin_0(pins[0]), .address_select_pin_1(pins[1]), .address_select_pin_2(pins[2]),
    .resistor0_position(pos[0]), .resistor1_position(pos[1]), .resistor2_position(pos[2]), .nv_busy(nv_busy));
  bus_master_model bus_master_model_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] dev_byte(input logic [2:0] p);
    return {4'ha, p, 1'b0};
  endfunction
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    srst = 1'b1;
    seed = 32'hea96_9200;
    pins = seed[11:9];
    exp_pos = {3{8'h7f}};
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (8) @(posedge mclk);
    check("reset positions", pos, exp_pos);
    bus_master_model_i.write_reg(dev_byte(~pins), 8'hf8, 8'h00, ak);
    check("foreign address", 24'({nv_busy, ak}), 24'h00_0000);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = (i < 4) ? 8'(32'h7fff_8000 >> (8 * i)) : seed[15:8];
      k = (i < 3) ? i : int'(seed[17:16]) % 3;
      bus_master_model_i.write_reg(dev_byte(pins), 8'hf8 + 8'(k), v, ak);
      check("write acks and busy", 24'({nv_busy, ak}), 24'h00_000f);
      check("positions while busy", pos, exp_pos);
      bus_master_model_i.write_reg(dev_byte(pins), 8'hf8, ~v, ak);
      check("poll while busy", 24'({nv_busy, ak}), 24'h00_0008);
      for (int w = 0; w < 500 && nv_busy !== 1'b0; w++) @(posedge mclk);
      exp_pos[k] = v;
      @(posedge mclk);
      check("positions after write", pos, exp_pos);
      bus_master_model_i.read_reg(dev_byte(pins), 8'hf8 + 8'(k), rd, ak);
      check("read back", {13'h0000, ak, rd}, {13'h0000, 3'h7, v});
    end
    bus_master_model_i.write_reg(dev_byte(pins), 8'hfb, 8'h55, ak);
    check("unmapped write", 24'({nv_busy, ak}), 24'h00_0007);
    bus_master_model_i.read_reg(dev_byte(pins), 8'hfb, rd, ak);
    check("unmapped read", {13'h0000, ak, rd}, {13'h0000, 3'h7, 8'h00});
    check("positions kept", pos, exp_pos);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("positions after reset", pos, {3{8'h7f}});
    give_verdict();
  end
endmodule
